// ==== logic/eic_arbiter.sv ====
module eic_arbiter
    import eic_pkg::*;
(
    input  wire logic [MAX_SRC-1:0]   cand_i,
    input  wire logic [MAX_SRC-1:0]   prio_lo_i,
    input  wire logic [MAX_SRC-1:0]   prio_hi_i,
    input  wire logic [NUM_LVL-1:0]   active_i,
    output logic                      hit_o,
    output logic [SRC_IDX_W-1:0]      win_o,
    output logic [LVL_W-1:0]          lvl_o
);

    // ************************************************************
    // Selection
    // ************************************************************
    // Scanning downward with >= lets the lowest index win a tie.
    always_comb begin
        logic [LVL_W:0]   thresh;
        logic [LVL_W-1:0] lvl;
        thresh = '0;
        lvl    = '0;
        hit_o  = 1'b0;
        win_o  = '0;
        lvl_o  = '0;
        for (int l = 0; l < NUM_LVL; l++) begin
            if (active_i[l]) begin
                thresh = (LVL_W+1)'(l + 1);
            end
        end
        for (int i = MAX_SRC - 1; i >= 0; i--) begin
            lvl = {prio_hi_i[i], prio_lo_i[i]};
            if (cand_i[i] && ({1'b0, lvl} >= thresh) &&
                (!hit_o || lvl >= lvl_o)) begin
                hit_o = 1'b1;
                win_o = SRC_IDX_W'(i);
                lvl_o = lvl;
            end
        end
    end

endmodule // eic_arbiter

// ==== logic/eic_ctrl.sv ====
// Operation
// - A source's valid condition sets its pending flag to one.
// - Pending flags set regardless of the source's enable state.
// - Request raised while a flag is pending and its source enabled.
// - At instruction end a long call goes to the source's service address.
// - Routines end with return; core resumes where it would have.
// - Pending flags of disabled sources raise no request.
// - One enable bit per source, spread over three enable registers.
// - Per-source enables count only while global enable bit 7 is one.
// - Global enable at zero suppresses every source.
// - Enable cleared just before a single-cycle instruction may still be taken.
// - Enable cleared before a multi-cycle instruction is never taken.
// - A cleared enable bit reads zero at once, even inside the routine.
// - Some flags clear on vectoring; software clears the rest.
// - Flag still set after return requests again, taken after one instruction.
// - Two-bit priority per source from high and low registers.
// - Higher level preempts a routine; level three is never preempted.
// - Highest level wins; equal levels fall back to fixed source order.
// - Software-written pending flags behave exactly like hardware-set ones; a same-cycle vectoring clear beats a write but not a new event.
//
// The implementer's own choices: the register addresses and the plain strobed port.
module eic_ctrl
    import eic_pkg::*;
#(
    parameter int                   NUM_SRC     = NUM_SRC_DEFAULT,
    parameter logic [VEC_TAB_W-1:0] VEC_TABLE   = eic_default_vectors(),
    parameter logic [MAX_SRC-1:0]   HW_CLR_MASK = HW_CLR_DEFAULT
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic [ADDR_W-1:0]    addr_i,
    input  wire logic [DATA_W-1:0]    wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [DATA_W-1:0]    rdata_o,
    input  wire logic [MAX_SRC-1:0]   src_event_i,
    input  wire logic [NUM_EXT-1:0]   ext_pin_i,
    input  wire logic                 insn_done_i,
    input  wire logic                 return_from_irq_insn_done_i,
    output logic                      irq_req_o,
    output logic                      call_o,
    output logic      [VEC_W-1:0]     call_addr_o,
    output logic      [SRC_IDX_W-1:0] call_src_o,
    output logic      [LVL_W-1:0]     call_lvl_o,
    output logic      [NUM_LVL-1:0]   active_o
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [DATA_W-1:0] get_seg(
        input logic [MAX_SRC-1:0] v,
        input logic [1:0]         seg
    );
        logic [DATA_W-1:0] r;
        r = '0;
        case (seg)
            SEG_PRI: r[SEG_PRI_W-1:0] = v[SEG_PRI_W-1:0];
            SEG_A:   r = v[SEG_A_LSB +: SEG_W];
            default: r = v[SEG_B_LSB +: SEG_W];
        endcase
        return r;
    endfunction

    function automatic logic [MAX_SRC-1:0] put_seg(
        input logic [MAX_SRC-1:0] v,
        input logic [1:0]         seg,
        input logic [DATA_W-1:0]  d
    );
        logic [MAX_SRC-1:0] r;
        r = v;
        case (seg)
            SEG_PRI: r[SEG_PRI_W-1:0] = d[SEG_PRI_W-1:0];
            SEG_A:   r[SEG_A_LSB +: SEG_W] = d;
            default: r[SEG_B_LSB +: SEG_W] = d;
        endcase
        return r;
    endfunction

    function automatic logic [NUM_LVL-1:0] pop_level(
        input logic [NUM_LVL-1:0] a
    );
        logic [NUM_LVL-1:0] r;
        logic               done;
        r    = a;
        done = 1'b0;
        for (int l = NUM_LVL - 1; l >= 0; l--) begin
            if (!done && a[l]) begin
                r[l] = 1'b0;
                done = 1'b1;
            end
        end
        return r;
    endfunction

    // ************************************************************
    // State and derived signals
    // ************************************************************
    eic_state_t           s_q;
    eic_state_t           s_d;
    logic [MAX_SRC-1:0]   src_mask;
    logic [MAX_SRC-1:0]   en_eff;
    logic                 glob_eff;
    logic [MAX_SRC-1:0]   cand;
    logic [NUM_EXT-1:0]   ext_act;
    logic [NUM_EXT-1:0]   ext_set;
    logic [MAX_SRC-1:0]   set_vec;
    logic [MAX_SRC-1:0]   clr_vec;
    logic [DATA_W-1:0]    rd_val;
    logic                 hit;
    logic [SRC_IDX_W-1:0] win;
    logic [LVL_W-1:0]     win_lvl;

    genvar gi;
    generate
        for (gi = 0; gi < MAX_SRC; gi++) begin : g_src
            assign src_mask[gi] = (gi < NUM_SRC);
        end
        for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
            assign ext_act[gi] = s_q.filt[gi] ^
                                 s_q.ext_cfg[EXTCFG_LOW_LSB + gi];
            assign ext_set[gi] = s_q.ext_cfg[EXTCFG_EDGE_LSB + gi] ?
                                 (ext_act[gi] & ~s_q.act_prev[gi]) :
                                 ext_act[gi];
        end
    endgenerate

    // A cleared enable keeps acting for one more cycle, so only an
    // instruction boundary one cycle later can still catch it.
    assign en_eff   = s_q.en | s_q.en_prev;
    assign glob_eff = s_q.glob | s_q.glob_prev;
    assign cand     = s_q.pend & en_eff & src_mask &
                      {MAX_SRC{glob_eff}};

    eic_arbiter u_arbiter (
        .cand_i    (cand),
        .prio_lo_i (s_q.prio_lo),
        .prio_hi_i (s_q.prio_hi),
        .active_i  (s_q.active),
        .hit_o     (hit),
        .win_o     (win),
        .lvl_o     (win_lvl)
    );

    // ************************************************************
    // Event collection
    // ************************************************************
    always_comb begin
        set_vec = src_event_i;
        for (int p = 0; p < NUM_EXT; p++) begin
            set_vec[EXT_SRC_MAP[p*SRC_IDX_W +: SRC_IDX_W]] =
                set_vec[EXT_SRC_MAP[p*SRC_IDX_W +: SRC_IDX_W]] |
                ext_set[p];
        end
    end

    // ************************************************************
    // Read mux
    // ************************************************************
    always_comb begin
        rd_val = '0;
        case (addr_i)
            ADDR_ENA_PRI: begin
                rd_val = get_seg(s_q.en, SEG_PRI);
                rd_val[GLOB_BIT] = s_q.glob;
            end
            ADDR_ENA_A:   rd_val = get_seg(s_q.en, SEG_A);
            ADDR_ENA_B:   rd_val = get_seg(s_q.en, SEG_B);
            ADDR_PLO_PRI: rd_val = get_seg(s_q.prio_lo, SEG_PRI);
            ADDR_PLO_A:   rd_val = get_seg(s_q.prio_lo, SEG_A);
            ADDR_PLO_B:   rd_val = get_seg(s_q.prio_lo, SEG_B);
            ADDR_PHI_PRI: rd_val = get_seg(s_q.prio_hi, SEG_PRI);
            ADDR_PHI_A:   rd_val = get_seg(s_q.prio_hi, SEG_A);
            ADDR_PHI_B:   rd_val = get_seg(s_q.prio_hi, SEG_B);
            ADDR_PND_PRI: rd_val = get_seg(s_q.pend, SEG_PRI);
            ADDR_PND_A:   rd_val = get_seg(s_q.pend, SEG_A);
            ADDR_PND_B:   rd_val = get_seg(s_q.pend, SEG_B);
            ADDR_STATUS: begin
                rd_val[STAT_ACT_LSB +: NUM_LVL] = s_q.active;
                rd_val[STAT_REQ_BIT] = hit;
            end
            ADDR_EXT_CFG: rd_val = s_q.ext_cfg;
            default:      rd_val = '0;
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d           = s_q;
        clr_vec       = '0;
        s_d.call      = 1'b0;
        s_d.en_prev   = s_q.en;
        s_d.glob_prev = s_q.glob;
        s_d.sync1     = ext_pin_i;
        s_d.sync2     = s_q.sync1;
        s_d.sync3     = s_q.sync2;
        for (int p = 0; p < NUM_EXT; p++) begin
            if (s_q.sync2[p] == s_q.sync3[p]) begin
                s_d.filt[p] = s_q.sync3[p];
            end
        end
        s_d.act_prev = ext_act;

        if (wr_i) begin
            case (addr_i)
                ADDR_ENA_PRI: begin
                    s_d.en   = put_seg(s_q.en, SEG_PRI, wdata_i);
                    s_d.glob = wdata_i[GLOB_BIT];
                end
                ADDR_ENA_A:   s_d.en = put_seg(s_q.en, SEG_A, wdata_i);
                ADDR_ENA_B:   s_d.en = put_seg(s_q.en, SEG_B, wdata_i);
                ADDR_PLO_PRI: s_d.prio_lo = put_seg(s_q.prio_lo, SEG_PRI,
                                                    wdata_i);
                ADDR_PLO_A:   s_d.prio_lo = put_seg(s_q.prio_lo, SEG_A,
                                                    wdata_i);
                ADDR_PLO_B:   s_d.prio_lo = put_seg(s_q.prio_lo, SEG_B,
                                                    wdata_i);
                ADDR_PHI_PRI: s_d.prio_hi = put_seg(s_q.prio_hi, SEG_PRI,
                                                    wdata_i);
                ADDR_PHI_A:   s_d.prio_hi = put_seg(s_q.prio_hi, SEG_A,
                                                    wdata_i);
                ADDR_PHI_B:   s_d.prio_hi = put_seg(s_q.prio_hi, SEG_B,
                                                    wdata_i);
                ADDR_PND_PRI: s_d.pend = put_seg(s_q.pend, SEG_PRI,
                                                 wdata_i);
                ADDR_PND_A:   s_d.pend = put_seg(s_q.pend, SEG_A,
                                                 wdata_i);
                ADDR_PND_B:   s_d.pend = put_seg(s_q.pend, SEG_B,
                                                 wdata_i);
                ADDR_EXT_CFG: s_d.ext_cfg = wdata_i;
                default: ;
            endcase
        end

        // The return boundary is never itself a take point, so one more
        // instruction always runs before a still-pending flag re-enters.
        if (return_from_irq_insn_done_i) begin
            s_d.active = pop_level(s_q.active);
        end else if (insn_done_i && hit) begin
            s_d.call          = 1'b1;
            s_d.call_src      = win;
            s_d.call_addr     = VEC_TABLE[win*VEC_W +: VEC_W];
            s_d.call_lvl      = win_lvl;
            s_d.active[win_lvl] = 1'b1;
            clr_vec[win]      = HW_CLR_MASK[win];
        end

        // A new event beats any clear in the same cycle.
        s_d.pend = ((s_d.pend & ~clr_vec) | set_vec) & src_mask;

        s_d.rdata = rd_i ? rd_val : '0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= EIC_STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign rdata_o     = s_q.rdata;
    assign irq_req_o   = hit;
    assign call_o      = s_q.call;
    assign call_addr_o = s_q.call_addr;
    assign call_src_o  = s_q.call_src;
    assign call_lvl_o  = s_q.call_lvl;
    assign active_o    = s_q.active;

endmodule // eic_ctrl

// ==== logic/eic_pkg.sv ====
package eic_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int MAX_SRC         = 23;
    localparam int NUM_SRC_DEFAULT = 18;
    localparam int SRC_IDX_W       = 5;
    localparam int NUM_LVL         = 4;
    localparam int LVL_W           = 2;
    localparam int NUM_EXT         = 2;
    localparam int ADDR_W          = 8;
    localparam int DATA_W          = 8;
    localparam int VEC_W           = 16;
    localparam int VEC_TAB_W       = VEC_W * MAX_SRC;

    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [ADDR_W-1:0] ADDR_ENA_PRI = 8'ha8;
    localparam logic [ADDR_W-1:0] ADDR_ENA_A   = 8'he6;
    localparam logic [ADDR_W-1:0] ADDR_ENA_B   = 8'he7;
    localparam logic [ADDR_W-1:0] ADDR_PLO_PRI = 8'hb8;
    localparam logic [ADDR_W-1:0] ADDR_PLO_A   = 8'hf6;
    localparam logic [ADDR_W-1:0] ADDR_PLO_B   = 8'hf7;
    localparam logic [ADDR_W-1:0] ADDR_PHI_PRI = 8'h84;
    localparam logic [ADDR_W-1:0] ADDR_PHI_A   = 8'hf4;
    localparam logic [ADDR_W-1:0] ADDR_PHI_B   = 8'hf5;
    localparam logic [ADDR_W-1:0] ADDR_PND_PRI = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_PND_A   = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_PND_B   = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_EXT_CFG = 8'h05;

    // ************************************************************
    // Field layout
    // ************************************************************
    localparam logic [1:0] SEG_PRI   = 2'h0;
    localparam logic [1:0] SEG_A     = 2'h1;
    localparam logic [1:0] SEG_B     = 2'h2;
    localparam int         SEG_PRI_W = 7;
    localparam int         SEG_A_LSB = 7;
    localparam int         SEG_B_LSB = 15;
    localparam int         SEG_W     = 8;
    localparam int         GLOB_BIT  = 7;
    localparam int STAT_ACT_LSB     = 0;
    localparam int STAT_REQ_BIT     = 4;
    localparam int EXTCFG_EDGE_LSB  = 0;
    localparam int EXTCFG_LOW_LSB   = 4;
    localparam logic [NUM_EXT*SRC_IDX_W-1:0] EXT_SRC_MAP = {5'h02, 5'h00};
    localparam logic [MAX_SRC-1:0] HW_CLR_DEFAULT = 23'h00000f;
    localparam logic [VEC_W-1:0]   VEC_BASE       = 16'h0003;
    localparam logic [VEC_W-1:0]   VEC_STEP       = 16'h0008;

    function automatic logic [VEC_TAB_W-1:0] eic_default_vectors();
        logic [VEC_TAB_W-1:0] t;
        t = '0;
        for (int i = 0; i < MAX_SRC; i++) begin
            t[i*VEC_W +: VEC_W] = VEC_BASE + VEC_STEP * VEC_W'(i);
        end
        return t;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [MAX_SRC-1:0]   pend;
        logic [MAX_SRC-1:0]   en;
        logic [MAX_SRC-1:0]   en_prev;
        logic [MAX_SRC-1:0]   prio_lo;
        logic [MAX_SRC-1:0]   prio_hi;
        logic                 glob;
        logic                 glob_prev;
        logic [NUM_LVL-1:0]   active;
        logic [DATA_W-1:0]    ext_cfg;
        logic [NUM_EXT-1:0]   sync1;
        logic [NUM_EXT-1:0]   sync2;
        logic [NUM_EXT-1:0]   sync3;
        logic [NUM_EXT-1:0]   filt;
        logic [NUM_EXT-1:0]   act_prev;
        logic                 call;
        logic [VEC_W-1:0]     call_addr;
        logic [SRC_IDX_W-1:0] call_src;
        logic [LVL_W-1:0]     call_lvl;
        logic [DATA_W-1:0]    rdata;
    } eic_state_t;

    localparam eic_state_t EIC_STATE_RST = '0;

endpackage

// ==== verif/eic_checker.sv ====
module eic_checker
    import eic_pkg::*;
#(
    parameter logic [VEC_TAB_W-1:0] VEC_TABLE = '0
) (
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic [ADDR_W-1:0]    addr_i,
    input wire logic [DATA_W-1:0]    wdata_i,
    input wire logic                 wr_i,
    input wire logic                 rd_i,
    input wire logic [DATA_W-1:0]    rdata_o,
    input wire logic                 insn_done_i,
    input wire logic                 return_from_irq_insn_done_i,
    input wire logic                 irq_req_o,
    input wire logic                 call_o,
    input wire logic [VEC_W-1:0]     call_addr_o,
    input wire logic [SRC_IDX_W-1:0] call_src_o,
    input wire logic [LVL_W-1:0]     call_lvl_o,
    input wire logic [NUM_LVL-1:0]   active_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ********************
    // Properties
    // ********************
    property p_take;
        insn_done_i && irq_req_o && !return_from_irq_insn_done_i |=> call_o;
    endproperty
    a_take: assert property (p_take)
        else $error("request taken without a call");
    property p_cause;
        call_o |-> $past(insn_done_i && irq_req_o && !return_from_irq_insn_done_i);
    endproperty
    a_cause: assert property (p_cause)
        else $error("call without a taken request");
    property p_vec;
        call_o |-> call_addr_o == VEC_TABLE[call_src_o*VEC_W +: VEC_W];
    endproperty
    a_vec: assert property (p_vec)
        else $error("service address does not match source");
    property p_act;
        call_o |-> active_o[call_lvl_o];
    endproperty
    a_act: assert property (p_act)
        else $error("called level not marked active");
    property p_top;
        active_o[NUM_LVL-1] |-> !irq_req_o;
    endproperty
    a_top: assert property (p_top)
        else $error("request while top level runs");
    property p_rd;
        !$past(rd_i) |-> rdata_o == '0;
    endproperty
    a_rd: assert property (p_rd)
        else $error("read data outside its cycle");
    // One extra cycle is allowed for the clear-enable race.
    property p_glob;
        wr_i && addr_i == ADDR_ENA_PRI && !wdata_i[GLOB_BIT]
            |=> ##1 !irq_req_o;
    endproperty
    a_glob: assert property (p_glob)
        else $error("request with global enable off");
    property p_pop;
        return_from_irq_insn_done_i && active_o != '0 |=> active_o < $past(active_o);
    endproperty
    a_pop: assert property (p_pop)
        else $error("return did not end a level");
endmodule // eic_checker

bind eic_ctrl eic_checker #(.VEC_TABLE(VEC_TABLE)) u_eic_checker (
    .clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .insn_done_i, .return_from_irq_insn_done_i, .irq_req_o, .call_o, .call_addr_o,
    .call_src_o, .call_lvl_o, .active_o
);

// ==== verif/eic_core_model.sv ====
module eic_core_model (
    input  wire logic clk_i,
    output logic      insn_done_o,
    output logic      return_from_irq_insn_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        insn_done_o = 1'b0;
        return_from_irq_insn_done_o = 1'b0;
    end
    // A gap above one stands for a slow, multi-cycle instruction.
    task automatic step(input int gap);
        repeat (gap) @(posedge clk_i);
        insn_done_o <= 1'b1;
        @(posedge clk_i);
        insn_done_o <= 1'b0;
    endtask
    // The return never coincides with a completion pulse.
    task automatic ret(input int gap);
        repeat (gap) @(posedge clk_i);
        return_from_irq_insn_done_o <= 1'b1;
        @(posedge clk_i);
        return_from_irq_insn_done_o <= 1'b0;
    endtask
endmodule // eic_core_model

// ==== verif/eic_ctrl_tb_top.sv ====
module eic_ctrl_tb_top
    import eic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0]  ea, ed, pa, pb;
        logic [4:0]  src;
        logic [15:0] vec;
    } eic_row_t;
    eic_row_t rows [4] = '{
        '{8'ha8, 8'h82, 8'h01, 8'h02, 5'h01, 16'h000b},
        '{8'ha8, 8'h90, 8'h01, 8'h10, 5'h04, 16'h0023},
        '{8'he6, 8'h04, 8'h02, 8'h04, 5'h09, 16'h004b},
        '{8'he7, 8'h04, 8'h03, 8'h04, 5'h11, 16'h008b}};
    logic [7:0] regs [11] = '{8'ha8, 8'he6, 8'he7, 8'hb8, 8'hf6, 8'hf7,
        8'h84, 8'hf4, 8'hf5, 8'h04, 8'h10};
    logic                 clk_i, rst_i, wr_i, rd_i, irq_req_o, call_o;
    logic                 insn_done, return_from_irq_insn_done;
    logic [7:0]           addr_i, wdata_i, rdata_o;
    logic [MAX_SRC-1:0]   src_event_i;
    logic [NUM_EXT-1:0]   ext_pin_i;
    logic [VEC_W-1:0]     call_addr_o;
    logic [SRC_IDX_W-1:0] call_src_o;
    logic [LVL_W-1:0]     call_lvl_o;
    logic [NUM_LVL-1:0]   active_o;
    int                   err_total, tests_run;

    eic_ctrl u_eic_ctrl (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .src_event_i(src_event_i), .ext_pin_i(ext_pin_i),
        .insn_done_i(insn_done), .return_from_irq_insn_done_i(return_from_irq_insn_done),
        .irq_req_o(irq_req_o), .call_o(call_o), .call_addr_o(call_addr_o),
        .call_src_o(call_src_o), .call_lvl_o(call_lvl_o),
        .active_o(active_o));
    eic_core_model u_eic_core_model (.clk_i(clk_i),
        .insn_done_o(insn_done), .return_from_irq_insn_done_o(return_from_irq_insn_done));

    // ********************
    // Tasks
    // ********************
    task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_call(input logic [21:0] g, input logic [21:0] e);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk_reg(rdata_o, e);
        @(posedge clk_i);
    endtask
    task automatic ev(input int s);
        src_event_i <= MAX_SRC'(s);
        @(posedge clk_i);
        src_event_i <= '0;
    endtask
    // Bounded wait; a missing call leaves call_o low and so mismatches.
    task automatic take(input logic [15:0] v, input logic [4:0] s);
        int n;
        n = 0;
        #1;
        while (call_o !== 1'b1 && n < 8) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk_call({call_o, call_src_o, call_addr_o}, {1'b1, s, v});
        @(posedge clk_i);
    endtask
    task automatic nocall();
        repeat (4) begin
            #1;
            chk_call({20'h0, irq_req_o, call_o}, 22'h0);
            @(posedge clk_i);
        end
    endtask
    task automatic tally_and_finish();
        $display("errors=%0d checks=%0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ********************
    // Sequence
    // ********************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        tally_and_finish();
    end
    initial begin
        {rst_i, wr_i, rd_i, addr_i, wdata_i} = {3'b100, 16'h0};
        {src_event_i, ext_pin_i, err_total, tests_run} = '0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i]) begin
            wr(8'ha8, 8'h80);
            wr(rows[i].ea, rows[i].ed);
            ev(1 << rows[i].src);
            rd(rows[i].pa, rows[i].pb);
            u_eic_core_model.step(1);
            take(rows[i].vec, rows[i].src);
            rd(rows[i].pa, HW_CLR_DEFAULT[rows[i].src] ?
               8'h00 : rows[i].pb);
            wr(rows[i].pa, 8'h00);
            u_eic_core_model.ret(1);
        end
        // Every source fires at once; bits past the source count stay 0.
        wr(8'ha8, 8'h00);
        ev(32'h7fffff);
        rd(8'h01, 8'h7f);
        rd(8'h02, 8'hff);
        rd(8'h03, 8'h07);
        // Second reset in mid-run; enable, priority and status registers must come back cleared.
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wr(8'h10, 8'hff);
        foreach (regs[i]) rd(regs[i], 8'h00);
        wr(8'ha8, 8'h20);
        ev(32'h20);
        rd(8'h01, 8'h20);
        u_eic_core_model.step(1);
        nocall();
        wr(8'ha8, 8'ha0);
        u_eic_core_model.step(3);
        take(16'h002b, 5'h05);
        u_eic_core_model.ret(1);
        u_eic_core_model.step(1);
        take(16'h002b, 5'h05);
        wr(8'h01, 8'h00);
        u_eic_core_model.ret(1);
        wr(8'ha8, 8'h80);
        wr(8'h01, 8'h20);
        u_eic_core_model.step(1);
        nocall();
        wr(8'hb8, 8'h40);
        wr(8'ha8, 8'hc4);
        ev(32'h44);
        u_eic_core_model.step(1);
        take(16'h0033, 5'h06);
        u_eic_core_model.step(1);
        nocall();
        wr(8'hb8, 8'h48);
        wr(8'h84, 8'h08);
        wr(8'ha8, 8'hcc);
        ev(32'h08);
        u_eic_core_model.step(1);
        take(16'h001b, 5'h03);
        chk_reg({2'b00, call_lvl_o, active_o}, 8'h3a);
        wr(8'h01, 8'h04);
        u_eic_core_model.ret(1);
        u_eic_core_model.ret(1);
        u_eic_core_model.step(1);
        take(16'h0013, 5'h02);
        u_eic_core_model.ret(1);
        wr(8'ha8, 8'h90);
        ev(32'h10);
        wr(8'ha8, 8'h10);
        wr(8'ha8, 8'h10);
        u_eic_core_model.step(2);
        nocall();
        rd(8'ha8, 8'h10);
        // A completion one cycle after the clearing write still takes.
        wr(8'ha8, 8'h90);
        fork
            wr(8'ha8, 8'h10);
            u_eic_core_model.step(1);
        join
        take(16'h0023, 5'h04);
        rd(8'ha8, 8'h10);
        u_eic_core_model.ret(1);
        wr(8'h01, 8'h00);
        wr(8'ha8, 8'h82);
        wr(8'h01, 8'h02);
        u_eic_core_model.step(1);
        take(16'h000b, 5'h01);
        u_eic_core_model.ret(1);
        wr(8'ha8, 8'h00);
        ext_pin_i <= 2'b11;
        repeat (8) @(posedge clk_i);
        ext_pin_i <= 2'b00;
        repeat (8) @(posedge clk_i);
        rd(8'h01, 8'h05);
        tally_and_finish();
    end
endmodule // eic_ctrl_tb_top
